// *** shared/drvref_map.svh ***
`ifndef DRVREF_MAP_SVH
`define DRVREF_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (word index within the reference area)
// ----------------------------------------------------------------
`define DRVREF_BANK_UPPER   12'h000
`define DRVREF_RUN_OFS      4'h1
`define DRVREF_SPEED_OFS    4'h2
`define DRVREF_TARGET_OFS   4'h6
`define DRVREF_AOUT1_OFS    4'h7
`define DRVREF_AOUT2_OFS    4'h8
`define DRVREF_CONTACT_OFS  4'h9
`define DRVREF_SELECT_OFS   4'hf

// ----------------------------------------------------------------
// Writable bit masks and reset value
// ----------------------------------------------------------------
`define DRVREF_FULL_MASK    16'hffff
`define DRVREF_CONTACT_MASK 16'h00df
`define DRVREF_SELECT_MASK  16'hf002
`define DRVREF_NONE_MASK    16'h0000
`define DRVREF_RESET_VALUE  16'h0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DRVREF_FWD_BIT      0
`define DRVREF_REV_BIT      1
`define DRVREF_EXTF_BIT     2
`define DRVREF_FRST_BIT     3
`define DRVREF_NETREF_BIT   4
`define DRVREF_NETRUN_BIT   5
`define DRVREF_INCMD_LO     6
`define DRVREF_INCMD_HI     15
`define DRVREF_RELAY_BIT    0
`define DRVREF_PHC_LO       1
`define DRVREF_PHC_HI       4
`define DRVREF_FOVR_BIT     6
`define DRVREF_FON_BIT      7
`define DRVREF_TGT_EN_BIT   1
`define DRVREF_BCAST_LO     12
`define DRVREF_BCAST_HI     15

// ----------------------------------------------------------------
// Analog output setting limits (+1540 and -1540)
// ----------------------------------------------------------------
`define DRVREF_AOUT_MAX     16'h0604
`define DRVREF_AOUT_MIN     16'hf9fc

`endif

// *** shared/drvref_pkg.sv ***
`default_nettype none
package drvref_pkg;

    typedef logic [15:0] drvref_word_t;

    typedef enum logic [1:0] {
        DRVREF_HIGH = 2'b01,
        DRVREF_LOW  = 2'b10
    } drvref_phase_t;

    typedef struct packed {
        drvref_phase_t phase;
        logic          writing;
        drvref_word_t  addr;
        logic [7:0]    high;
        logic          rd_valid;
        logic [7:0]    rd_data;
    } drvref_pair_t;

    typedef struct packed {
        logic [15:0][15:0] regs;
    } drvref_bank_t;

    typedef struct packed {
        logic         forward_run;
        logic         reverse_run;
        logic         external_fault_input;
        logic         fault_reset;
        logic         network_reference_select;
        logic         network_run_select;
        logic [9:0]   input_command;
        drvref_word_t speed_setpoint;
        drvref_word_t loop_target;
        logic         loop_target_enable;
        drvref_word_t analog_out_one;
        drvref_word_t analog_out_two;
        logic         relay_contact_terminal;
        logic [3:0]   photocoupler_output;
        logic         fault_contact_terminal;
        logic [3:0]   broadcast_input_enable;
    } drvref_out_t;

endpackage
`default_nettype wire

// *** shared/drvref_word_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface drvref_word_if;
    logic        wr_valid;
    logic [15:0] addr;
    logic [15:0] wr_data;
    logic [15:0] rd_word;

    modport pair  (output wr_valid, addr, wr_data, input rd_word);
    modport watch (input wr_valid, addr, wr_data);
endinterface
`default_nettype wire

// *** hdl/drvref_pair.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "drvref_map.svh"
module drvref_pair (
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    input  wire logic         access_start,
    input  wire logic         access_write,
    input  wire logic [15:0]  access_addr,
    input  wire logic         byte_valid,
    input  wire logic [7:0]   byte_data,
    input  wire logic         byte_req,
    output logic              rd_valid,
    output logic [7:0]        rd_data,
    drvref_word_if.pair       w
);
    import drvref_pkg::*;

    drvref_pair_t s;
    drvref_pair_t next_s;

    // ------------------------------------------------------------
    // Byte pairing: high byte first, address ascending
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.rd_valid = 1'b0;
        if (access_start)
        begin
            next_s.addr    = access_addr;
            next_s.writing = access_write;
            next_s.phase   = DRVREF_HIGH;
        end
        else if (byte_valid && s.writing)
        begin
            if (s.phase == DRVREF_HIGH)
            begin
                next_s.high  = byte_data;                    // [RQ16]
                next_s.phase = DRVREF_LOW;
            end
            else
            begin
                next_s.phase = DRVREF_HIGH;
                next_s.addr  = s.addr + 16'h0001;            // [RQ16]
            end
        end
        else if (byte_req && !s.writing)
        begin
            next_s.rd_valid = 1'b1;
            if (s.phase == DRVREF_HIGH)
            begin
                next_s.rd_data = w.rd_word[15:8];            // [RQ16]
                next_s.phase   = DRVREF_LOW;
            end
            else
            begin
                next_s.rd_data = w.rd_word[7:0];
                next_s.phase   = DRVREF_HIGH;
                next_s.addr    = s.addr + 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s <= '{phase: DRVREF_HIGH, writing: 1'b0, addr: 16'h0000,
                   high: 8'h00, rd_valid: 1'b0, rd_data: 8'h00};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign w.wr_valid = byte_valid && s.writing && !access_start
                        && (s.phase == DRVREF_LOW);
    assign w.addr     = s.addr;
    assign w.wr_data  = {s.high, byte_data};
    assign rd_valid   = s.rd_valid;
    assign rd_data    = s.rd_data;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_high_first: assert property (@(posedge ref_clk) disable iff (!nrst) // [RQ16]
        byte_req && !s.writing && !access_start && s.phase == DRVREF_HIGH
        |=> rd_valid && rd_data == $past(w.rd_word[15:8]))
        else $error("read did not return the high byte first");
    a_word_advance: assert property (@(posedge ref_clk) disable iff (!nrst) // [RQ16]
        w.wr_valid |=> w.addr == $past(w.addr) + 16'h0001)
        else $error("address did not advance after a word");
endmodule
`default_nettype wire

// *** hdl/drvref_drive.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "drvref_map.svh"
module drvref_drive (
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    input  wire logic [15:0]  run_word,
    input  wire logic [15:0]  speed_word,
    input  wire logic [15:0]  target_word,
    input  wire logic [15:0]  aout1_word,
    input  wire logic [15:0]  aout2_word,
    input  wire logic [15:0]  contact_word,
    input  wire logic [15:0]  select_word,
    input  wire logic         drive_fault_state,
    drvref_word_if.watch      w,
    output drvref_pkg::drvref_out_t q
);
    import drvref_pkg::*;

    drvref_out_t next_q;

    function automatic drvref_word_t clamp(input drvref_word_t v);
        if ($signed(v) > $signed(`DRVREF_AOUT_MAX))
            return `DRVREF_AOUT_MAX;
        else if ($signed(v) < $signed(`DRVREF_AOUT_MIN))
            return `DRVREF_AOUT_MIN;
        else
            return v;
    endfunction

    // ------------------------------------------------------------
    // Drive side decode of the stored words
    // ------------------------------------------------------------
    always_comb
    begin
        next_q = q;
        next_q.forward_run  = run_word[`DRVREF_FWD_BIT];            // [RQ2]
        next_q.reverse_run  = run_word[`DRVREF_REV_BIT];            // [RQ3]
        next_q.external_fault_input = run_word[`DRVREF_EXTF_BIT];   // [RQ4]
        // Reset is a command: one pulse per write carrying the bit
        next_q.fault_reset  = w.wr_valid
            && w.addr == {`DRVREF_BANK_UPPER, `DRVREF_RUN_OFS}
            && w.wr_data[`DRVREF_FRST_BIT];                         // [RQ5]
        next_q.network_reference_select = run_word[`DRVREF_NETREF_BIT];
        next_q.network_run_select = run_word[`DRVREF_NETRUN_BIT];
        next_q.input_command =
            run_word[`DRVREF_INCMD_HI:`DRVREF_INCMD_LO];            // [RQ6]
        next_q.speed_setpoint = speed_word;                         // [RQ7]
        next_q.loop_target    = target_word;
        next_q.loop_target_enable = select_word[`DRVREF_TGT_EN_BIT]; // [RQ12]
        next_q.analog_out_one = clamp(aout1_word);                  // [RQ8]
        next_q.analog_out_two = clamp(aout2_word);                  // [RQ8]
        next_q.relay_contact_terminal = contact_word[`DRVREF_RELAY_BIT]; // [RQ9]
        next_q.photocoupler_output =
            contact_word[`DRVREF_PHC_HI:`DRVREF_PHC_LO];            // [RQ10]
        next_q.fault_contact_terminal = contact_word[`DRVREF_FOVR_BIT]
            ? contact_word[`DRVREF_FON_BIT] : drive_fault_state;    // [RQ11]
        next_q.broadcast_input_enable =
            select_word[`DRVREF_BCAST_HI:`DRVREF_BCAST_LO];         // [RQ13]
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end
endmodule
`default_nettype wire

// *** hdl/drvref_bank.sv ***
// What this block does
// (RQ1) Every reference word is readable and writable; here reserved words and unused bits drop writes and read zero
// (RQ2) Run word bit 0 requests forward run
// (RQ3) Run word bit 1 requests reverse run
// (RQ4) Run word bit 2 raises external fault
// (RQ5) Writing run bit 3 issues fault reset
// (RQ6) Run bits 6-15 are input commands 3-12
// (RQ7) Word 2 holds the speed setpoint
// (RQ8) Words 7, 8 are analog settings +-1540
// (RQ9) Contact bit 0 drives the relay contact
// (RQ10) Contact bits 1-4 drive photocouplers 1-4
// (RQ11) Contact bit 6 lets bit 7 drive fault
// (RQ12) Select bit 1 enables the loop target
// (RQ13) Select bits 12-15 enable broadcast inputs 5-8
// (RQ14) Master writes zero into unused bits
// (RQ15) Master never writes reserved addresses
// (RQ16) Words travel high byte first, ascending
// (RQ17) Each word holds until written again
`timescale 1ns/1ps
`default_nettype none
`include "drvref_map.svh"
module drvref_bank (
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    input  wire logic         access_start,
    input  wire logic         access_write,
    input  wire logic [15:0]  access_addr,
    input  wire logic         byte_valid,
    input  wire logic [7:0]   byte_data,
    input  wire logic         byte_req,
    input  wire logic         drive_fault_state,
    output logic              rd_valid,
    output logic [7:0]        rd_data,
    output logic              forward_run,
    output logic              reverse_run,
    output logic              external_fault_input,
    output logic              fault_reset,
    output logic              network_reference_select,
    output logic              network_run_select,
    output logic [9:0]        input_command,
    output logic [15:0]       speed_setpoint,
    output logic [15:0]       loop_target,
    output logic              loop_target_enable,
    output logic [15:0]       analog_out_one,
    output logic [15:0]       analog_out_two,
    output logic              relay_contact_terminal,
    output logic              photocoupler_output_1,
    output logic              photocoupler_output_2,
    output logic              photocoupler_output_3,
    output logic              photocoupler_output_4,
    output logic              fault_contact_terminal,
    output logic [3:0]        broadcast_input_enable
);
    import drvref_pkg::*;

    drvref_word_if w ();

    drvref_bank_t s;
    drvref_bank_t next_s;
    drvref_out_t  q;

    logic [15:0][15:0] wmask;
    logic              in_bank;
    logic [3:0]        idx;

    // ------------------------------------------------------------
    // Writable bits per word; reserved words keep nothing
    // ------------------------------------------------------------
    function automatic drvref_word_t mask_of(input logic [3:0] i);
        unique case (i)
            `DRVREF_RUN_OFS,
            `DRVREF_SPEED_OFS,
            `DRVREF_TARGET_OFS,
            `DRVREF_AOUT1_OFS,
            `DRVREF_AOUT2_OFS:   return `DRVREF_FULL_MASK;
            `DRVREF_CONTACT_OFS: return `DRVREF_CONTACT_MASK;
            `DRVREF_SELECT_OFS:  return `DRVREF_SELECT_MASK;
            default:             return `DRVREF_NONE_MASK;
        endcase
    endfunction

    for (genvar i = 0; i < 16; i++)
    begin : g_mask
        assign wmask[i] = mask_of(4'(i));
    end

    // ------------------------------------------------------------
    // Byte stream to word access
    // ------------------------------------------------------------
    drvref_pair u_pair (
        .ref_clk      (ref_clk),
        .nrst         (nrst),
        .access_start (access_start),
        .access_write (access_write),
        .access_addr  (access_addr),
        .byte_valid   (byte_valid),
        .byte_data    (byte_data),
        .byte_req     (byte_req),
        .rd_valid     (rd_valid),
        .rd_data      (rd_data),
        .w            (w.pair)
    );

    assign in_bank = (w.addr[15:4] == `DRVREF_BANK_UPPER);
    assign idx     = w.addr[3:0];

    // ------------------------------------------------------------
    // Storage: unused bits and reserved words stay zero
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        if (w.wr_valid && in_bank)
        begin
            next_s.regs[idx] = w.wr_data & wmask[idx];       // [RQ1] [RQ14]
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s <= '{regs: {16{`DRVREF_RESET_VALUE}}};
        end
        else
        begin
            s <= next_s;                                     // [RQ17]
        end
    end

    // Reads outside the bank return zero
    assign w.rd_word = in_bank ? s.regs[idx] : 16'h0000;     // [RQ1] [RQ15]

    // ------------------------------------------------------------
    // Registered drive outputs
    // ------------------------------------------------------------
    drvref_drive u_drive (
        .ref_clk           (ref_clk),
        .nrst              (nrst),
        .run_word          (s.regs[`DRVREF_RUN_OFS]),
        .speed_word        (s.regs[`DRVREF_SPEED_OFS]),
        .target_word       (s.regs[`DRVREF_TARGET_OFS]),
        .aout1_word        (s.regs[`DRVREF_AOUT1_OFS]),
        .aout2_word        (s.regs[`DRVREF_AOUT2_OFS]),
        .contact_word      (s.regs[`DRVREF_CONTACT_OFS]),
        .select_word       (s.regs[`DRVREF_SELECT_OFS]),
        .drive_fault_state (drive_fault_state),
        .w                 (w.watch),
        .q                 (q)
    );

    assign forward_run              = q.forward_run;
    assign reverse_run              = q.reverse_run;
    assign external_fault_input     = q.external_fault_input;
    assign fault_reset              = q.fault_reset;
    assign network_reference_select = q.network_reference_select;
    assign network_run_select       = q.network_run_select;
    assign input_command            = q.input_command;
    assign speed_setpoint           = q.speed_setpoint;
    assign loop_target              = q.loop_target;
    assign loop_target_enable       = q.loop_target_enable;
    assign analog_out_one           = q.analog_out_one;
    assign analog_out_two           = q.analog_out_two;
    assign relay_contact_terminal   = q.relay_contact_terminal;
    assign photocoupler_output_1    = q.photocoupler_output[0];
    assign photocoupler_output_2    = q.photocoupler_output[1];
    assign photocoupler_output_3    = q.photocoupler_output[2];
    assign photocoupler_output_4    = q.photocoupler_output[3];
    assign fault_contact_terminal   = q.fault_contact_terminal;
    assign broadcast_input_enable   = q.broadcast_input_enable;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    a_write_stores: assert property ( // [RQ1]
        w.wr_valid && in_bank
        |=> s.regs[$past(idx)] == ($past(w.wr_data) & wmask[$past(idx)]))
        else $error("written word not stored");
    a_word_holds: assert property ( // [RQ17]
        !(w.wr_valid && in_bank) |=> s.regs == $past(s.regs))
        else $error("word changed without a write");
    a_forward_run: assert property ( // [RQ2]
        w.wr_valid && in_bank && idx == `DRVREF_RUN_OFS
        |=> ##1 forward_run == $past(w.wr_data[`DRVREF_FWD_BIT], 2))
        else $error("forward run not following run word");
    a_reverse_run: assert property ( // [RQ3]
        reverse_run == $past(s.regs[`DRVREF_RUN_OFS][`DRVREF_REV_BIT]))
        else $error("reverse run not following run word");
    a_ext_fault: assert property ( // [RQ4]
        external_fault_input
        == $past(s.regs[`DRVREF_RUN_OFS][`DRVREF_EXTF_BIT]))
        else $error("external fault not following run word");
    a_fault_reset_pulse: assert property ( // [RQ5]
        w.wr_valid && in_bank && idx == `DRVREF_RUN_OFS
        && w.wr_data[`DRVREF_FRST_BIT]
        |=> fault_reset ##1 (fault_reset == $past(w.wr_valid)))
        else $error("fault reset pulse wrong");
    a_input_cmds: assert property ( // [RQ6]
        input_command
        == $past(s.regs[`DRVREF_RUN_OFS][`DRVREF_INCMD_HI:`DRVREF_INCMD_LO]))
        else $error("input commands misordered");
    a_speed_word: assert property ( // [RQ7]
        speed_setpoint == $past(s.regs[`DRVREF_SPEED_OFS]))
        else $error("speed setpoint not following word");
    a_aout_range: assert property ( // [RQ8]
        $signed(analog_out_one) <= $signed(`DRVREF_AOUT_MAX)
        && $signed(analog_out_one) >= $signed(`DRVREF_AOUT_MIN)
        && $signed(analog_out_two) <= $signed(`DRVREF_AOUT_MAX)
        && $signed(analog_out_two) >= $signed(`DRVREF_AOUT_MIN))
        else $error("analog setting out of range");
    a_relay_out: assert property ( // [RQ9]
        relay_contact_terminal
        == $past(s.regs[`DRVREF_CONTACT_OFS][`DRVREF_RELAY_BIT]))
        else $error("relay contact not following word");
    a_photo_out: assert property ( // [RQ10]
        {photocoupler_output_4, photocoupler_output_3,
         photocoupler_output_2, photocoupler_output_1}
        == $past(s.regs[`DRVREF_CONTACT_OFS][`DRVREF_PHC_HI:`DRVREF_PHC_LO]))
        else $error("photocoupler outputs wrong");
    a_fault_contact: assert property ( // [RQ11]
        $past(s.regs[`DRVREF_CONTACT_OFS][`DRVREF_FOVR_BIT])
        |-> fault_contact_terminal
            == $past(s.regs[`DRVREF_CONTACT_OFS][`DRVREF_FON_BIT]))
        else $error("fault contact override ignored");
    a_target_enable: assert property ( // [RQ12]
        loop_target_enable
        == $past(s.regs[`DRVREF_SELECT_OFS][`DRVREF_TGT_EN_BIT]))
        else $error("loop target enable wrong");
    a_bcast_enable: assert property ( // [RQ13]
        broadcast_input_enable
        == $past(s.regs[`DRVREF_SELECT_OFS][`DRVREF_BCAST_HI:`DRVREF_BCAST_LO]))
        else $error("broadcast enables wrong");
    a_unused_zero: assert property ( // [RQ14]
        (s.regs[`DRVREF_CONTACT_OFS] & ~`DRVREF_CONTACT_MASK) == 16'h0000
        && (s.regs[`DRVREF_SELECT_OFS] & ~`DRVREF_SELECT_MASK) == 16'h0000)
        else $error("unused bit stored");
    a_reserved_read: assert property ( // [RQ15]
        (!in_bank || wmask[idx] == `DRVREF_NONE_MASK) |-> w.rd_word == 16'h0000)
        else $error("reserved word reads nonzero");

    c_forward_run:  cover property (!forward_run ##[1:40] forward_run);
    c_fault_reset:  cover property (fault_reset);
    c_fault_ovr:    cover property (fault_contact_terminal
                                    && !drive_fault_state);
    c_read_pair:    cover property (rd_valid ##1 rd_valid);
endmodule
`default_nettype wire

// *** test/drvref_master.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Link master: byte stream, one byte per cycle
// ----------------------------------------------------------------
module drvref_master (
    input  wire logic        ref_clk,
    output logic             access_start,
    output logic             access_write,
    output logic [15:0]      access_addr,
    output logic             byte_valid,
    output logic [7:0]       byte_data,
    output logic             byte_req
);
    initial
    begin
        {access_start, access_write, byte_valid, byte_req} = 4'h0;
        access_addr = 16'h0000;
        byte_data = 8'h5a;
    end

    task automatic send(input logic wr, input logic [15:0] a, input int n,
                        input logic [15:0] d [$]);
        @(negedge ref_clk);
        access_start <= 1'b1;
        access_write <= wr;
        access_addr <= a;
        for (int i = 0; i < 2 * n; i++)
        begin
            @(negedge ref_clk);
            access_start <= 1'b0;
            byte_valid <= wr;
            byte_req <= !wr;
            // High byte first, then low, words ascending
            byte_data <= wr ? (i[0] ? d[i/2][7:0] : d[i/2][15:8]) : 8'h00;
        end
        @(negedge ref_clk);
        access_start <= 1'b0;
        byte_valid <= 1'b0;
        byte_req <= 1'b0;
        // Released data must not keep its last value
        byte_data <= ~byte_data;
    endtask
endmodule
`default_nettype wire

// *** test/tb_drvref_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_drvref_bank;
    import drvref_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic drive_fault_state = 1'b0;
    logic access_start, access_write, byte_valid, byte_req, rd_valid;
    logic [15:0] access_addr, speed_setpoint, loop_target, r, s;
    logic [15:0] analog_out_one, analog_out_two;
    logic [7:0] byte_data, rd_data;
    logic forward_run, reverse_run, external_fault_input, fault_reset;
    logic network_reference_select, network_run_select, loop_target_enable;
    logic relay_contact_terminal, fault_contact_terminal;
    logic photocoupler_output_1, photocoupler_output_2;
    logic photocoupler_output_3, photocoupler_output_4;
    logic [9:0] input_command;
    logic [3:0] broadcast_input_enable;
    logic [7:0] exp_q [$];
    logic [15:0] z [$];
    int error_cnt = 0;
    int comparisons = 0;
    int pulses = 0;

    drvref_bank u_drvref_bank (.ref_clk, .nrst, .access_start, .access_write,
        .access_addr, .byte_valid, .byte_data, .byte_req, .drive_fault_state,
        .rd_valid, .rd_data, .forward_run, .reverse_run, .external_fault_input,
        .fault_reset, .network_reference_select, .network_run_select,
        .input_command, .speed_setpoint, .loop_target, .loop_target_enable,
        .analog_out_one, .analog_out_two, .relay_contact_terminal,
        .photocoupler_output_1, .photocoupler_output_2,
        .photocoupler_output_3, .photocoupler_output_4,
        .fault_contact_terminal, .broadcast_input_enable);
    drvref_master u_drvref_master (.ref_clk, .access_start, .access_write,
        .access_addr, .byte_valid, .byte_data, .byte_req);

    always #4 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // Checking, verdict and bus helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen,
                     exp);
        end
    endtask

    task automatic close_out();
        $display("counts: %0d compared, %0d wrong", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d [$]);
        u_drvref_master.send(1'b1, a, d.size(), d);
        @(negedge ref_clk);
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] d [$]);
        foreach (d[i])
        begin
            exp_q.push_back(d[i][15:8]);
            exp_q.push_back(d[i][7:0]);
        end
        u_drvref_master.send(1'b0, a, d.size(), d);
        repeat (2) @(negedge ref_clk);
    endtask

    always @(negedge ref_clk)
        if (rd_valid === 1'b1)
            check(16'(rd_data), 16'(exp_q.pop_front()));

    // Fault reset stands one cycle, mid-transfer: count every pulse seen
    always @(negedge ref_clk)
        if (fault_reset === 1'b1)
            pulses++;

    initial
    begin
        #50000;
        error_cnt++;
        close_out();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        r = 16'($urandom(76));
        repeat (4) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (16) z.push_back(16'h0000);
        rd(16'h0000, z);
        $display("test reset read done");
        r = 16'($urandom);
        r[3] = 1'b1;
        s = 16'($urandom);
        wr(16'h0001, '{r, s});
        check(16'({reverse_run, forward_run}), 16'(r[1:0]));
        check(16'(external_fault_input), 16'(r[2]));
        check(16'(pulses), 16'h0001);
        check(16'({network_run_select, network_reference_select}),
              16'(r[5:4]));
        check(16'(input_command), 16'(r[15:6]));
        check(speed_setpoint, s);
        @(negedge ref_clk);
        check(16'(fault_reset), 16'h0000);
        rd(16'h0001, '{r, s});
        $display("test run word done");
        s = 16'($urandom_range(1540));
        wr(16'h0006, '{r ^ s, 16'h0700, 16'hf000});
        check(loop_target, r ^ s);
        check(analog_out_one, 16'h0604);
        check(analog_out_two, 16'hf9fc);
        wr(16'h0007, '{s, -s});
        check(analog_out_one, s);
        check(analog_out_two, -s);
        rd(16'h0006, '{r ^ s, s, -s});
        $display("test analog done");
        for (int k = 0; k < 6; k++)
        begin
            s = 16'($urandom) & 16'h00df;
            s[6] = k[0];
            drive_fault_state = 1'($urandom);
            wr(16'h0009, '{s});
            check(16'({photocoupler_output_4, photocoupler_output_3,
                       photocoupler_output_2, photocoupler_output_1,
                       relay_contact_terminal}), 16'(s[4:0]));
            check(16'(fault_contact_terminal),
                  16'(s[6] ? s[7] : drive_fault_state));
            r = 16'($urandom) & 16'hf002;
            r[1] = k[1];
            wr(16'h000f, '{r});
            check(16'(loop_target_enable), 16'(r[1]));
            check(16'(broadcast_input_enable), 16'(r[15:12]));
            rd(16'h0009, '{s});
            rd(16'h000f, '{r});
        end
        $display("test contact and select done");
        wr(16'h0003, '{16'h1234});
        rd(16'h0003, '{16'h0000});
        check(16'(exp_q.size()), 16'h0000);
        $display("test reserved done");
        close_out();
    end
endmodule
`default_nettype wire
